//--- core/ccr_regs.v
// Power-on configuration and charge current registers of the charger.
// Assumes the serial engine presents decoded register writes/reads,
// one byte per strobe, with address already advancing per byte.
// Handshake answer is combinational; every setting leaves through a flip-flop.
//
// Operation
// - Writing one to bit 7 of the power-on configuration returns all configuration registers to defaults.
// - A register reset only restores contents and leaves the operating mode untouched; here the defaults it loads also turn boost off and charging on.
// - Writing one to bit 6 restarts the watchdog timer; zero does nothing.
// - The boost-output enable resets to zero and one enables boost.
// - While boost is enabled the charge enable is ignored and no charging occurs.
// - The charge enable resets to one; zero disables charging.
// - Minimum system voltage is 3.0 V plus 0.1 V per code step in bits 3:1, reset 101.
// - Fast-charge current is 512 mA plus 64 mA per code in bits 7:2, reset 011000.
// - Bit 1 selects the boost cold threshold, 76 % at zero, 79 % at one, reset zero.
// - The force bit cuts fast charge to 20 % and pre-charge to 50 %.
// - The charge current register resets to 01100000.
// - The device answers at address 0x6B and registers 0 to 7 are read/write.
// - Multi-byte access advances the register address across registers 0 to 8.
`timescale 1ns/1ps
`include "ccr_defines.vh"

module ccr_regs #(
    parameter WD_GAP_CYC = `CCR_WD_GAP_CYC
) (
    clk,
    sys_rst,
    reg_wr,
    reg_rd,
    reg_addr,
    reg_wdata,
    reg_rdata,
    reg_ack,
    prechg_ma,
    cfg_rst_other,
    wd_restart,
    wd_gap_viol,
    boost_en,
    charge_active,
    boost_lim_hi,
    sysmin_mv,
    bcold_sel,
    fast_ma,
    prechg_eff_ma,
    fast_charge_current_over
);
    input  wire        clk;
    input  wire        sys_rst;
    input  wire        reg_wr;
    input  wire        reg_rd;
    input  wire [7:0]  reg_addr;
    input  wire [7:0]  reg_wdata;
    output reg  [7:0]  reg_rdata;
    output wire        reg_ack;
    input  wire [11:0] prechg_ma;
    output reg         cfg_rst_other;
    output reg         wd_restart;
    output reg         wd_gap_viol;
    output reg         boost_en;
    output reg         charge_active;
    output reg         boost_lim_hi;
    output reg  [11:0] sysmin_mv;
    output reg         bcold_sel;
    output wire [11:0] fast_ma;
    output wire [11:0] prechg_eff_ma;
    output reg         fast_charge_current_over;

    reg  [7:0]  pwr_cfg_ff;
    reg  [7:0]  chg_cur_ff;
    reg  [15:0] wd_gap_ff;
    reg  [7:0]  nxt_pwr_cfg;
    reg  [7:0]  nxt_chg_cur;
    wire        wr_pwr;
    wire        wr_chg;
    wire        do_reg_rst;
    wire        do_wd;

    // Address decode; this block owns two of the eight writable indices.
    // Strobes last one cycle, so decode stays combinational and the
    // stored value changes at the taking edge.
    assign wr_pwr     = reg_wr && (reg_addr == `CCR_ADDR_PWR_CFG);
    assign wr_chg     = reg_wr && (reg_addr == `CCR_ADDR_CHG_CUR);
    assign do_reg_rst = wr_pwr && reg_wdata[`CCR_BIT_REG_RST];
    assign do_wd      = wr_pwr && reg_wdata[`CCR_BIT_WD_RST];
    // Accept any index in the auto-advance range so multi-byte bursts continue.
    // Index 8 is read only, so a write there is refused; index 9 and up is
    // refused both ways and the serial engine answers not-acknowledge.
    assign reg_ack    = (reg_wr && reg_addr <= `CCR_ADDR_LAST_RW) ||
                        (reg_rd && reg_addr <= `CCR_ADDR_LAST_MULTI);

    // Next register contents; command bits are self-clearing.
    // A register reset wins over the byte that carries it: the other bits
    // of that byte are dropped, so the host always reads the defaults back.
    always @* begin
        nxt_pwr_cfg = pwr_cfg_ff;
        nxt_chg_cur = chg_cur_ff;
        if (do_reg_rst) begin
            nxt_pwr_cfg = `CCR_PWR_CFG_RST;
            nxt_chg_cur = `CCR_CHG_CUR_RST;
        end else begin
            if (wr_pwr) begin
                nxt_pwr_cfg = {2'b00, reg_wdata[5:0]};
            end
            if (wr_chg) begin
                nxt_chg_cur = reg_wdata;
            end
        end
    end

    // Register storage with fixed reset values.
    // Defaults: boost off, charging on, 3.5 V floor, 1.5 A boost limit,
    // 2048 mA fast charge and no reduced-current force.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_cfg_ff <= `CCR_PWR_CFG_RST;
            chg_cur_ff <= `CCR_CHG_CUR_RST;
        end else begin
            pwr_cfg_ff <= nxt_pwr_cfg;
            chg_cur_ff <= nxt_chg_cur;
        end
    end

    // Command pulses: other registers reset, watchdog restart.
    // The mode bits follow the restored defaults, so the register reset turns boost off and charging on.
    // Both are single-cycle pulses; a consumer that needs a level must hold it.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_rst_other <= 1'b0;
            wd_restart    <= 1'b0;
        end else begin
            cfg_rst_other <= do_reg_rst;
            wd_restart    <= do_wd;
        end
    end

    // Spacing monitor for watchdog restarts; flags a too-early repeat.
    // Every restart reloads the counter, so a burst of early restarts keeps
    // flagging until the host leaves one full gap; zero means a restart is welcome.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wd_gap_ff   <= 16'h0000;
            wd_gap_viol <= 1'b0;
        end else begin
            wd_gap_viol <= do_wd && (wd_gap_ff != 16'h0000);
            if (do_wd) begin
                wd_gap_ff <= WD_GAP_CYC[15:0];
            end else if (wd_gap_ff != 16'h0000) begin
                wd_gap_ff <= wd_gap_ff - 16'h0001;
            end
        end
    end

    // Mode bits toward the power stage; boost masks the charge enable
    // in the same flop so the two are never seen on together
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            boost_en      <= 1'b0;
            charge_active <= 1'b0;
            boost_lim_hi  <= 1'b0;
        end else begin
            boost_en      <= pwr_cfg_ff[`CCR_BIT_BOOST_EN];
            charge_active <= pwr_cfg_ff[`CCR_BIT_CHG_EN] &&
                             !pwr_cfg_ff[`CCR_BIT_BOOST_EN];
            boost_lim_hi  <= pwr_cfg_ff[`CCR_BIT_BOOST_LIM];
        end
    end

    // Minimum system voltage in millivolts; sized constants keep the sum
    // at 12 bits, and the top code lands at 3700 mV
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysmin_mv <= 12'h000;
        end else begin
            sysmin_mv <= `CCR_SYSMIN_BASE_MV + `CCR_SYSMIN_STEP_MV *
                         pwr_cfg_ff[`CCR_SYSMIN_MSB:`CCR_SYSMIN_LSB];
        end
    end

    // Cold threshold select and out-of-range current flag; codes above the
    // limit are still stored so the host reads back what it wrote
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bcold_sel <= 1'b0;
            fast_charge_current_over <= 1'b0;
        end else begin
            bcold_sel <= chg_cur_ff[`CCR_BIT_BCOLD];
            fast_charge_current_over <= chg_cur_ff[`CCR_FAST_CHARGE_CURRENT_MSB:`CCR_FAST_CHARGE_CURRENT_LSB] >
                         `CCR_FAST_CHARGE_CURRENT_MAX_CODE;
        end
    end

    // Registered read data; other indices return zero here.
    // Every read reloads the byte, so no stale value stands after a refused read.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CCR_ADDR_PWR_CFG: reg_rdata <= pwr_cfg_ff;
                `CCR_ADDR_CHG_CUR: reg_rdata <= chg_cur_ff;
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

    // Current scaling with reduced-current force; one more flop stage,
    // so the effective currents follow a write by two cycles
    ccr_scale u_scale (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .fast_code     (chg_cur_ff[`CCR_FAST_CHARGE_CURRENT_MSB:`CCR_FAST_CHARGE_CURRENT_LSB]),
        .prechg_ma     (prechg_ma),
        .force_red     (chg_cur_ff[`CCR_BIT_FORCE]),
        .fast_ma       (fast_ma),
        .prechg_eff_ma (prechg_eff_ma)
    );
endmodule

//--- core/ccr_defines.vh
// Register offsets, field positions, reset values and timing counts for
// the charger configuration / current register pair.
// Assumes inclusion by bare name from the core design files.
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

// Serial slave address (7 bit) and register indices
`define CCR_SLAVE_ADDR      7'h6B
`define CCR_ADDR_PWR_CFG    8'h01
`define CCR_ADDR_CHG_CUR    8'h02
`define CCR_ADDR_LAST_RW    8'h07
`define CCR_ADDR_LAST_MULTI 8'h08

// Reset values
`define CCR_PWR_CFG_RST     8'h1B
`define CCR_CHG_CUR_RST     8'h60

// Power-on configuration field positions
`define CCR_BIT_REG_RST     7
`define CCR_BIT_WD_RST      6
`define CCR_BIT_BOOST_EN    5
`define CCR_BIT_CHG_EN      4
`define CCR_SYSMIN_MSB      3
`define CCR_SYSMIN_LSB      1
`define CCR_BIT_BOOST_LIM   0

// Charge current field positions
`define CCR_FAST_CHARGE_CURRENT_MSB        7
`define CCR_FAST_CHARGE_CURRENT_LSB        2
`define CCR_BIT_BCOLD       1
`define CCR_BIT_FORCE       0

// Electrical scale (millivolts / milliamperes), sized to the 12-bit outputs
`define CCR_SYSMIN_BASE_MV  12'h0bb8
`define CCR_SYSMIN_STEP_MV  12'h064
`define CCR_FAST_CHARGE_CURRENT_BASE_MA    12'h200
`define CCR_FAST_CHARGE_CURRENT_STEP_MA    12'h040
`define CCR_FAST_CHARGE_CURRENT_MAX_CODE   6'h27

// Least watchdog-restart spacing, in ns, and clock period in ns
`define CCR_WD_GAP_NS       20000
`define CCR_CLK_PERIOD_NS   4
`define CCR_WD_GAP_CYC      ((`CCR_WD_GAP_NS + `CCR_CLK_PERIOD_NS - 1) / `CCR_CLK_PERIOD_NS)

`endif

//--- core/ccr_scale.v
// Converts the stored current code into effective fast-charge and
// pre-charge targets, applying the reduced-current force.
// Assumes codes come straight from registers; output is registered.
`timescale 1ns/1ps
`include "ccr_defines.vh"

module ccr_scale (
    clk,
    sys_rst,
    fast_code,
    prechg_ma,
    force_red,
    fast_ma,
    prechg_eff_ma
);
    input  wire        clk;
    input  wire        sys_rst;
    input  wire [5:0]  fast_code;
    input  wire [11:0] prechg_ma;
    input  wire        force_red;
    output reg  [11:0] fast_ma;
    output reg  [11:0] prechg_eff_ma;

    wire [11:0] full_ma;
    wire [27:0] fifth_ma;

    // Base plus weighted code
    assign full_ma  = `CCR_FAST_CHARGE_CURRENT_BASE_MA + {fast_code, 6'b00_0000};
    // One fifth as multiply by 0x3334 over 2^16; exact floor for 12-bit inputs
    assign fifth_ma = {16'h0000, full_ma} * 28'h000_3334;

    // Reduced current selects 20 % fast and 50 % pre-charge
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_ma       <= 12'h000;
            prechg_eff_ma <= 12'h000;
        end else if (force_red) begin
            fast_ma       <= fifth_ma[27:16];
            prechg_eff_ma <= {1'b0, prechg_ma[11:1]};
        end else begin
            fast_ma       <= full_ma;
            prechg_eff_ma <= prechg_ma;
        end
    end
endmodule

//--- tb/ccr_props.sv
// Port checks for the charger register pair.
// Assumes a bind into ccr_regs; one clock, async reset high.
`timescale 1ns/1ps
module ccr_props #(
    parameter WD_GAP_CYC = 8
) (
    input wire        clk, sys_rst, reg_wr, reg_rd, reg_ack,
    input wire [7:0]  reg_addr, reg_wdata, reg_rdata,
    input wire [11:0] prechg_ma, sysmin_mv, fast_ma, prechg_eff_ma,
    input wire        cfg_rst_other, wd_restart, wd_gap_viol, boost_en,
    input wire        charge_active, boost_lim_hi, bcold_sel, fast_charge_current_over
);
    // Decoded write strobes
    wire cfg_wr = reg_wr && reg_addr == 8'h01;
    wire cur_wr = reg_wr && reg_addr == 8'h02;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    reg_reset_a:
        assert property (cfg_wr && reg_wdata[7] |=> cfg_rst_other ##1 (!boost_en && charge_active
            && boost_lim_hi && sysmin_mv == 12'hdac)) else $error("register reset missed");
    wd_pulse_a:
        assert property (cfg_wr && reg_wdata[6] |=> wd_restart) else $error("no restart");
    wd_quiet_a:
        assert property (!(cfg_wr && reg_wdata[6]) |=> !wd_restart) else $error("stray restart");
    wd_gap_a:
        assert property (wd_gap_viol |-> $past(cfg_wr && reg_wdata[6])) else $error("stray gap");
    boost_prio_a:
        assert property (boost_en |-> !charge_active) else $error("charging in boost");
    ack_range_a:
        assert property (reg_ack == ((reg_wr && reg_addr <= 8'h07) || (reg_rd && reg_addr <= 8'h08)))
            else $error("ack decode wrong");
    cfg_field_a:
        assert property (cfg_wr && !reg_wdata[7] |-> ##2 (boost_lim_hi == $past(reg_wdata[0], 2)
            && sysmin_mv == 12'hbb8 + 12'h064 * $past(reg_wdata[3:1], 2))) else $error("cfg field");
    fast_code_a:
        assert property (cur_wr && !reg_wdata[0] |-> ##2
            fast_ma == 12'h200 + 12'h040 * $past(reg_wdata[7:2], 2)) else $error("fast current");
    over_code_a:
        assert property (cur_wr |-> ##2 (fast_charge_current_over == ($past(reg_wdata[7:2], 2) > 6'h27)
            && bcold_sel == $past(reg_wdata[1], 2))) else $error("code flags");
    force_half_a:
        assert property (cur_wr && reg_wdata[0] |-> ##2 prechg_eff_ma == (prechg_ma >> 1))
            else $error("pre-charge not halved");
    cover property (cfg_wr && reg_wdata[7]);
    cover property (wd_gap_viol);
    cover property (cur_wr && reg_wdata[0]);
endmodule
bind ccr_regs ccr_props #(.WD_GAP_CYC(WD_GAP_CYC)) props_u (.clk, .sys_rst, .reg_wr, .reg_rd,
    .reg_ack, .reg_addr, .reg_wdata, .reg_rdata, .prechg_ma, .sysmin_mv, .fast_ma, .prechg_eff_ma,
    .cfg_rst_other, .wd_restart, .wd_gap_viol, .boost_en, .charge_active, .boost_lim_hi,
    .bcold_sel, .fast_charge_current_over);

//--- tb/ccr_host.sv
// Host model issuing one-byte register strobes.
// Assumes the bench calls xfer and idle; changes land at falling edges.
`timescale 1ns/1ps
module ccr_host (
    input  wire       clk,
    input  wire       reg_ack,
    input  wire [7:0] reg_rdata,
    output reg        reg_wr = 1'b0,
    output reg        reg_rd = 1'b0,
    output reg  [7:0] reg_addr = 8'h00,
    output reg  [7:0] reg_wdata = 8'h00
);
    // Request held to the taking edge; answer taken there
    task xfer(input wr, input [7:0] a, input [7:0] d, output ack, output [7:0] rdat);
        begin
            @(negedge clk);
            reg_wr = wr;
            reg_rd = !wr;
            reg_addr = a;
            reg_wdata = wr ? d : ~reg_wdata;
            @(posedge clk);
            ack = reg_ack;
            #1;
            rdat = reg_rdata;
        end
    endtask
    // Release; lines flip so stale values cannot match
    task idle;
        begin
            @(negedge clk);
            reg_wr = 1'b0;
            reg_rd = 1'b0;
            reg_addr = ~reg_addr;
            reg_wdata = ~reg_wdata;
        end
    endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the charger register pair.
// Assumes ccr_regs with a short watchdog spacing of 8 cycles.
`timescale 1ns/1ps
module testbench;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [11:0] prechg_ma = 12'h100;
    wire        reg_wr, reg_rd, reg_ack, cfg_rst_other, wd_restart, wd_gap_viol, boost_en;
    wire        charge_active, boost_lim_hi, bcold_sel, fast_charge_current_over;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire [11:0] sysmin_mv, fast_ma, prechg_eff_ma;
    reg         ack;
    reg  [7:0]  rdat;
    integer     n_fail = 0;
    integer     n_tests = 0;
    integer     cyc = 0;
    ccr_host host_u (.clk, .reg_ack, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    ccr_regs #(.WD_GAP_CYC(8)) dut_u (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_ack, .prechg_ma, .cfg_rst_other, .wd_restart, .wd_gap_viol, .boost_en,
        .charge_active, .boost_lim_hi, .sysmin_mv, .bcold_sel, .fast_ma, .prechg_eff_ma,
        .fast_charge_current_over);
    // Clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end
    task chk(input string what, input [11:0] seen, input [11:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        host_u.xfer(1'b1, a, d, ack, rdat);
    endtask
    task rd(input [7:0] a);
        host_u.xfer(1'b0, a, 8'h00, ack, rdat);
    endtask
    // Release bus and let decoded outputs land
    task settle;
        begin
            host_u.idle;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task t_fields;
        begin
            wr(8'h01, 8'h3e);
            wr(8'h02, 8'h9e);
            settle;
            chk("modes", {boost_en, charge_active, boost_lim_hi, bcold_sel}, 4'b1001);
            chk("sysmin", sysmin_mv, 12'he74);
            chk("fast", fast_ma, 12'hbc0);
            chk("over", fast_charge_current_over, 1'b0);
            rd(8'h02);
            chk("cur", rdat, 8'h9e);
            wr(8'h02, 8'ha0);
            wr(8'h01, 8'h10);
            settle;
            chk("over", fast_charge_current_over, 1'b1);
            chk("modes", {boost_en, charge_active, boost_lim_hi, bcold_sel}, 4'b0100);
            chk("sysmin", sysmin_mv, 12'hbb8);
            wr(8'h02, 8'h61);
            settle;
            chk("fast", fast_ma, 12'h199);
            chk("pre", prechg_eff_ma, 12'h080);
            wr(8'h01, 8'h0b);
            settle;
            chk("modes", {boost_en, charge_active, boost_lim_hi, bcold_sel}, 4'b0010);
            $display("test fields done");
        end
    endtask
    task t_regrst;
        begin
            wr(8'h02, 8'h9e);
            wr(8'h01, 8'h3e);
            wr(8'h01, 8'hbe);
            chk("rst pulse", cfg_rst_other, 1'b1);
            settle;
            rd(8'h01);
            chk("cfg", rdat, 8'h1b);
            rd(8'h02);
            chk("cur", rdat, 8'h60);
            settle;
            chk("fast", fast_ma, 12'h800);
            chk("pre", prechg_eff_ma, 12'h100);
            chk("modes", {boost_en, charge_active, boost_lim_hi, bcold_sel}, 4'b0110);
            $display("test reset done");
        end
    endtask
    task t_wd;
        begin
            wr(8'h01, 8'h5b);
            chk("restart", {wd_restart, wd_gap_viol}, 2'b10);
            wr(8'h01, 8'h5b);
            chk("gap", wd_gap_viol, 1'b1);
            host_u.idle;
            repeat (12) @(posedge clk);
            wr(8'h01, 8'h5b);
            chk("restart", {wd_restart, wd_gap_viol}, 2'b10);
            rd(8'h01);
            chk("selfclr", rdat, 8'h1b);
            wr(8'h01, 8'h1b);
            chk("quiet", wd_restart, 1'b0);
            wr(8'h08, 8'h00);
            chk("ack w8", ack, 1'b0);
            rd(8'h08);
            chk("ack r8", ack, 1'b1);
            rd(8'h09);
            chk("ack r9", {ack, rdat}, 9'h000);
            host_u.idle;
            $display("test watchdog done");
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        t_regrst;
        t_fields;
        t_wd;
        report_and_stop;
    end
endmodule
